// ### verilog/gtimer_pkg.sv
// constants, types and helpers for the general timer channel
// assumes one 200 MHz system clock; control bits arrive as plain ports
// Operation
// - every channel has a 16-bit counter and reload register, running independently
// - channels share no counting state; one channel never disturbs another
// - mode register bits 0 and 1 pick timer, event, one-shot or pwm mode; here one-shot and pwm only hold the counter
// - timer mode counts down on undivided, div-8, div-32 or subclock div-32 ticks
// - timer underflow reloads the counter and raises the interrupt request
// - timer with value n underflows once every n+1 source ticks
// - counting only while start flag is 1; clearing it holds the value
// - stopped write loads reload and counter; running write loads reload only
// - the live counter value is always readable
// - timer gate function lets count input pin level enable counting
// - timer pulse output inverts the output pin on every underflow
// - event source: pin edge, second-group timer two flow, other timer flow
// - channels 0 and 1 single-phase only; two-phase decoding lives elsewhere
// - event direction from software bit or output pin used as input
// - event ratio is 1/(ffff-n+1) counting up, 1/(n+1) counting down
// - event reload type reloads on overflow or underflow and raises request
// - free-run wraps without reload yet still raises the request
// - event pulse output inverts the output pin on overflow or underflow
// - mode field 01 selects event counter mode
// - count-type bit: 0 reload, 1 free-run in event mode
package gtimer_pkg;
  localparam int unsigned   CNT_W       = 16;
  localparam int unsigned   MR_W        = 8;
  localparam logic [15:0]   CNT_MAX     = 16'hffff;
  localparam logic [15:0]   CNT_ZERO    = 16'h0000;
  localparam logic [7:0]    MR_RESET    = 8'h00;
  // mode register field positions
  localparam int unsigned   MR_MODE_LO  = 0;
  localparam int unsigned   MR_MODE_HI  = 1;
  localparam int unsigned   MR_PULSE    = 2;
  localparam int unsigned   MR_GATE_EDG = 3;
  localparam int unsigned   MR_LVL_DIR  = 4;
  localparam int unsigned   MR_COUNT_TY = 6;
  localparam int unsigned   MR_CLK_HI   = 7;
  typedef enum logic [1:0] {
    MODE_TIMER   = 2'b00,
    MODE_EVENT   = 2'b01,
    MODE_ONESHOT = 2'b10,
    MODE_PWM     = 2'b11
  } mode_t;
  typedef enum logic [1:0] {ST_STOP = 2'b01, ST_RUN = 2'b10} run_t;
  localparam logic [1:0]    CLK_UNDIV   = 2'h0;
  localparam logic [1:0]    CLK_DIV8    = 2'h1;
  localparam logic [1:0]    CLK_DIV32   = 2'h2;
  localparam logic [1:0]    CLK_SUB32   = 2'h3;
  localparam logic [1:0]    SRC_PIN     = 2'h0;
  localparam logic [1:0]    SRC_SECOND  = 2'h1;
  localparam logic [1:0]    SRC_OTHER   = 2'h2;
  // prescaler ratios
  localparam int unsigned   DIV8        = 8;
  localparam int unsigned   DIV32       = 32;
  localparam logic [4:0]    DIV8_LAST   = 5'(DIV8 - 1);
  localparam logic [4:0]    DIV32_LAST  = 5'(DIV32 - 1);
  // one count step up or down
  function automatic logic [15:0] count_step(input logic [15:0] c, input logic up);
    count_step = up ? 16'(c + 16'h0001) : 16'(c - 16'h0001);
  endfunction
endpackage

// ### verilog/pin_sync.sv
// two-flop synchroniser with edge detect for one asynchronous pin
// assumes the pin is unrelated to i_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // asynchronous pin
  input  wire logic i_pin,
  // synchronised level and edges
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic [2:0] fill;
  } sync_t;
  sync_t st_q, st_d;

  // meta is read only by sync
  always_comb begin
    st_d      = st_q;
    st_d.meta = i_pin;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
    st_d.fill = {st_q.fill[1:0], 1'b1}; // full once prev holds a real sample
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // edges from the settled stages only; none while the stages refill after
  // reset, so a pin idling high gives no false rise
  assign o_level = st_q.sync;
  assign o_rise  = st_q.fill[2] & st_q.sync & ~st_q.prev;
  assign o_fall  = st_q.fill[2] & ~st_q.sync & st_q.prev;
endmodule
`default_nettype wire

// ### verilog/clock_prescaler.sv
// prescaler: div-8 and div-32 of the clock, div-32 of subclock edges
// assumes subclock rises arrive already synchronised, one cycle each
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // synchronised subclock rising edge
  input  wire logic i_sub_rise,
  // one-cycle tick enables
  output logic      o_div8,
  output logic      o_div32,
  output logic      o_sub32
);
  import gtimer_pkg::*;
  typedef struct packed {
    logic [4:0] main;
    logic [4:0] sub;
    logic       d8;
    logic       d32;
    logic       s32;
  } pre_t;
  pre_t st_q, st_d;

  // free-running dividers
  always_comb begin
    st_d      = st_q;
    st_d.main = 5'(st_q.main + 5'h01);
    st_d.d8   = (st_q.main[2:0] == DIV8_LAST[2:0]);
    st_d.d32  = (st_q.main == DIV32_LAST);
    st_d.s32  = i_sub_rise && (st_q.sub == DIV32_LAST);
    if (i_sub_rise) begin
      st_d.sub = 5'(st_q.sub + 5'h01);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_div8  = st_q.d8;
  assign o_div32 = st_q.d32;
  assign o_sub32 = st_q.s32;
endmodule
`default_nettype wire

// ### verilog/general_timer_channel.sv
// one 16-bit general timer channel: timer mode and single-phase event mode
// assumes control ports come from logic on i_clk; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module general_timer_channel #(
  parameter int unsigned CHANNEL = 0
) (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rstn,
  // software control
  input  wire logic [gtimer_pkg::MR_W-1:0] i_channel_mode_register,
  input  wire logic [1:0]                  i_event_src,
  input  wire logic                        i_dir_up,
  input  wire logic                        i_start,
  // timer register write
  input  wire logic                        i_wr,
  input  wire logic [gtimer_pkg::CNT_W-1:0] i_wr_data,
  // asynchronous pins
  input  wire logic                        i_count_input_pin,
  input  wire logic                        i_timer_output_pin,
  input  wire logic                        i_subclock,
  // flow pulses of neighbour timers
  input  wire logic                        i_second_group_timer_two_flow,
  input  wire logic                        i_other_first_group_timer_flow,
  // counter state
  output logic [gtimer_pkg::CNT_W-1:0]     o_count,
  output logic [gtimer_pkg::CNT_W-1:0]     o_reload,
  output logic                             o_running,
  // events
  output logic                             o_irq,
  output logic                             o_flow,
  // output pin
  output logic                             o_timer_output_pin,
  output logic                             o_timer_output_pin_oe
);
  import gtimer_pkg::*;

  typedef struct packed {
    run_t        run;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic        irq;
    logic        flow;
    logic        tog;
    logic        oe;
  } state_t;
  state_t st_q, st_d;

  logic       in_level;
  logic       in_rise;
  logic       in_fall;
  logic       dir_level;
  logic       sub_rise;
  logic       tick_div8;
  logic       tick_div32;
  logic       tick_sub32;
  mode_t      mode;
  logic [1:0] clk_sel;
  logic       pulse_en;
  logic       gate_en;
  logic       edge_rising;
  logic       gate_high;
  logic       dir_from_pin;
  logic       freerun;
  logic       running;
  logic       presc_tick;
  logic       gate_ok;
  logic       pin_ev;
  logic       ev_tick;
  logic       tick;
  logic       up;
  logic       hit;
  logic       reload_on_hit;
  logic [15:0] rld_src;

  // pin synchronisers
  pin_sync u_sync_count (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_pin   (i_count_input_pin),
    .o_level (in_level),
    .o_rise  (in_rise),
    .o_fall  (in_fall)
  );

  pin_sync u_sync_dir (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_pin   (i_timer_output_pin),
    .o_level (dir_level),
    .o_rise  (),
    .o_fall  ()
  );

  pin_sync u_sync_sub (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_pin   (i_subclock),
    .o_level (),
    .o_rise  (sub_rise),
    .o_fall  ()
  );

  // count source prescaler
  clock_prescaler u_presc (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_sub_rise (sub_rise),
    .o_div8     (tick_div8),
    .o_div32    (tick_div32),
    .o_sub32    (tick_sub32)
  );

  // mode register fields
  assign mode         = mode_t'(i_channel_mode_register[MR_MODE_HI:MR_MODE_LO]);
  assign pulse_en     = i_channel_mode_register[MR_PULSE];
  assign gate_en      = i_channel_mode_register[MR_GATE_EDG];
  assign edge_rising  = i_channel_mode_register[MR_GATE_EDG];
  assign gate_high    = i_channel_mode_register[MR_LVL_DIR];
  assign dir_from_pin = i_channel_mode_register[MR_LVL_DIR];
  assign freerun      = i_channel_mode_register[MR_COUNT_TY];
  assign clk_sel      = i_channel_mode_register[MR_CLK_HI:MR_COUNT_TY];
  assign running      = (st_q.run == ST_RUN);

  // timer count source select
  always_comb begin
    presc_tick = 1'b0;
    unique case (clk_sel)
      CLK_UNDIV: presc_tick = 1'b1;
      CLK_DIV8:  presc_tick = tick_div8;
      CLK_DIV32: presc_tick = tick_div32;
      CLK_SUB32: presc_tick = tick_sub32;
    endcase
  end

  // gate on pin level, active level selectable
  assign gate_ok = !gate_en || (in_level == gate_high);
  assign pin_ev  = edge_rising ? in_rise : in_fall;

  // event count source select
  always_comb begin
    ev_tick = 1'b0;
    unique case (i_event_src)
      SRC_PIN:    ev_tick = pin_ev;
      SRC_SECOND: ev_tick = i_second_group_timer_two_flow;
      SRC_OTHER:  ev_tick = i_other_first_group_timer_flow;
      default:    ev_tick = 1'b0;
    endcase
  end

  // per-mode tick, direction and reload behaviour
  always_comb begin
    tick          = 1'b0;
    up            = 1'b0;
    reload_on_hit = 1'b1;
    unique case (mode)
      MODE_TIMER: begin
        tick = presc_tick && gate_ok;
      end
      MODE_EVENT: begin
        tick          = ev_tick;
        up            = dir_from_pin ? dir_level : i_dir_up;
        reload_on_hit = !freerun;
      end
      MODE_ONESHOT: begin
        tick = 1'b0;
      end
      MODE_PWM: begin
        tick = 1'b0;
      end
    endcase
  end

  // overflow at ffff counting up, underflow at 0 counting down
  assign hit     = (st_q.cnt == (up ? CNT_MAX : CNT_ZERO));
  assign rld_src = i_wr ? i_wr_data : st_q.rld;

  // next state of the channel
  always_comb begin
    st_d      = st_q;
    st_d.irq  = 1'b0;
    st_d.flow = 1'b0;
    st_d.run  = i_start ? ST_RUN : ST_STOP;
    st_d.oe   = pulse_en && !(mode == MODE_EVENT && dir_from_pin);
    if (i_wr) begin
      st_d.rld = i_wr_data;
      if (!running) begin
        st_d.cnt = i_wr_data;
      end
    end
    if (running && tick) begin
      if (hit) begin
        st_d.irq  = 1'b1;
        st_d.flow = 1'b1;
        if (pulse_en) begin
          st_d.tog = ~st_q.tog;
        end
        if (reload_on_hit) begin
          st_d.cnt = rld_src;
        end else begin
          st_d.cnt = count_step(st_q.cnt, up);
        end
      end else begin
        st_d.cnt = count_step(st_q.cnt, up);
      end
    end
  end

  // state register, cleared to stopped with zero count and reload
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '{run: ST_STOP, cnt: CNT_ZERO, rld: CNT_ZERO, default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign o_count               = st_q.cnt;
  assign o_reload              = st_q.rld;
  assign o_running             = st_q.run[1];
  assign o_irq                 = st_q.irq;
  assign o_flow                = st_q.flow;
  assign o_timer_output_pin    = st_q.tog;
  assign o_timer_output_pin_oe = st_q.oe;

  // checks on counting behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_tmr_tick;
    running && mode == MODE_TIMER && tick && !i_wr;
  endsequence

  sequence s_evt_hit;
    running && mode == MODE_EVENT && tick && hit && !i_wr;
  endsequence

  sequence s_pin_step;
    running && mode == MODE_EVENT && i_event_src == SRC_PIN && pin_ev && !hit && !i_wr;
  endsequence

  property p_stop_hold;
    !running && !i_wr |=> $stable(o_count) && !o_irq;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stopped counter changed");

  property p_tmr_dec;
    s_tmr_tick ##0 o_count != CNT_ZERO |=> o_count == count_step($past(o_count), 1'b0);
  endproperty
  a_tmr_dec: assert property (p_tmr_dec)
    else $error("timer did not count down by one");

  property p_tmr_reload;
    s_tmr_tick ##0 o_count == CNT_ZERO |=> o_count == $past(o_reload) && o_irq;
  endproperty
  a_tmr_reload: assert property (p_tmr_reload)
    else $error("timer underflow did not reload");

  property p_stop_write;
    !running && i_wr |=> o_count == $past(i_wr_data) && o_reload == $past(i_wr_data);
  endproperty
  a_stop_write: assert property (p_stop_write)
    else $error("stopped write missed counter");

  property p_run_write;
    running && i_wr && !tick |=> $stable(o_count) && o_reload == $past(i_wr_data);
  endproperty
  a_run_write: assert property (p_run_write)
    else $error("running write touched counter");

  property p_gate;
    running && mode == MODE_TIMER && !gate_ok && !i_wr |=> $stable(o_count);
  endproperty
  a_gate: assert property (p_gate)
    else $error("closed gate let counter move");

  property p_toggle;
    running && tick && hit && pulse_en |=> o_irq && o_timer_output_pin != $past(o_timer_output_pin);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("output pin did not invert on flow");

  property p_evt_reload;
    s_evt_hit ##0 !freerun |=> o_count == $past(o_reload) && o_irq;
  endproperty
  a_evt_reload: assert property (p_evt_reload)
    else $error("event flow did not reload");

  property p_freerun;
    s_evt_hit ##0 freerun |=> o_count == count_step($past(o_count), $past(up)) && o_irq;
  endproperty
  a_freerun: assert property (p_freerun)
    else $error("free-run flow did not wrap");

  property p_pin_step;
    s_pin_step |=> o_count == count_step($past(o_count), $past(up)) && !o_irq;
  endproperty
  a_pin_step: assert property (p_pin_step)
    else $error("pin edge did not move count by one");

  property p_idle_modes;
    (mode == MODE_ONESHOT || mode == MODE_PWM) && !i_wr |=> $stable(o_count);
  endproperty
  a_idle_modes: assert property (p_idle_modes)
    else $error("unbuilt mode moved counter");

  property p_irq_cause;
    o_irq |-> $past(running && tick && hit);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("request without flow");
endmodule
`default_nettype wire

// ### testbench/pin_partner.sv
// partner model: count pin, direction pin and subclock sources
// assumes the bench calls its tasks from the falling edge of i_clk
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // clock
  input  wire logic i_clk,
  // pins toward the channel
  output logic      o_count_pin,
  output logic      o_dir_pin,
  output logic      o_subclock
);
  logic       sub_en;
  logic [1:0] sub_div;
  initial begin
    o_count_pin = 1'b1;
    o_dir_pin   = 1'b0;
    o_subclock  = 1'b0;
    sub_en      = 1'b0;
    sub_div     = 2'h0;
  end
  // subclock of eight clocks a period, still while disabled
  always @(posedge i_clk) begin
    sub_div <= sub_en ? sub_div + 2'h1 : 2'h0;
    if (!sub_en) begin
      o_subclock <= 1'b0;
    end else if (sub_div == 2'h3) begin
      o_subclock <= ~o_subclock;
    end
  end
  // pin levels and subclock enable
  task automatic set_pins(input logic cnt, input logic dir, input logic sub);
    o_count_pin = cnt;
    o_dir_pin   = dir;
    sub_en      = sub;
  endtask
  // n low pulses, each level held four clocks so the synchroniser sees it
  task automatic pulses(input int n);
    for (int k = 0; k < n; k++) begin
      repeat (4) @(negedge i_clk);
      o_count_pin = 1'b0;
      repeat (4) @(negedge i_clk);
      o_count_pin = 1'b1;
    end
    repeat (6) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/general_timer_count_modes_tb.sv
// self-checking bench for one general timer channel
// assumes the pin partner model; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module general_timer_count_modes_tb;
  import gtimer_pkg::*;
  logic        clk, rstn, wr, start, dir_up, flow2, flow_o, irq, run, pin_q, oe, flw, p0;
  logic [1:0]  seen;
  logic        cpin, dpin, spin, tout;
  logic [7:0]  mr;
  logic [1:0]  src;
  logic [15:0] wdata, count, reload, c;
  int          num_errors, check_count, g;
  int          exp_gap [3] = '{8, 32, 256};

  // two-way output pin: partner drives only while the channel does not
  assign tout = oe ? pin_q : dpin;

  general_timer_channel #(.CHANNEL(0)) general_timer_channel_i (
    .i_clk(clk), .i_rstn(rstn), .i_channel_mode_register(mr), .i_event_src(src),
    .i_dir_up(dir_up), .i_start(start), .i_wr(wr), .i_wr_data(wdata),
    .i_count_input_pin(cpin), .i_timer_output_pin(tout), .i_subclock(spin),
    .i_second_group_timer_two_flow(flow2), .i_other_first_group_timer_flow(flow_o),
    .o_count(count), .o_reload(reload), .o_running(run), .o_irq(irq), .o_flow(flw),
    .o_timer_output_pin(pin_q), .o_timer_output_pin_oe(oe));

  pin_partner pin_partner_i (.i_clk(clk), .o_count_pin(cpin), .o_dir_pin(dpin),
    .o_subclock(spin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one timer register write
  task automatic wrt(input logic [15:0] v);
    wr = 1'b1;
    wdata = v;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // stop, reconfigure, load while stopped, start again
  task automatic cfg(input logic [7:0] m, input logic [1:0] s, input logic d,
                     input logic [15:0] v);
    start = 1'b0;
    repeat (2) @(negedge clk);
    mr = m;
    src = s;
    dir_up = d;
    wrt(v);
    start = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // cycles between two request pulses
  task automatic irq_gap(output int gap);
    int w;
    w = 0;
    while (irq !== 1'b1 && w < 2000) begin
      @(negedge clk);
      w++;
    end
    gap = 0;
    do begin
      @(negedge clk);
      gap++;
    end while (irq !== 1'b1 && gap < 2000);
  endtask

  // one neighbour flow pulse; reports a request seen after it
  task automatic flow(input logic other, output logic [1:0] s);
    s = 2'h0;
    if (other) flow_o = 1'b1;
    else flow2 = 1'b1;
    @(negedge clk);
    flow_o = 1'b0;
    flow2 = 1'b0;
    repeat (3) begin
      if (irq === 1'b1) s[0] = 1'b1;
      if (flw === 1'b1) s[1] = 1'b1;
      @(negedge clk);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #250000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0; wr = 1'b0; start = 1'b0; dir_up = 1'b0; flow2 = 1'b0; flow_o = 1'b0;
    mr = 8'h00; src = 2'h0; wdata = 16'h0000; num_errors = 0; check_count = 0;
    repeat (16) @(negedge clk);
    chk({run, oe, pin_q, 13'h0}, 16'h0, "reset flags");
    chk(count, 16'h0000, "reset count");
    rstn = 1'b1;
    @(negedge clk);
    wrt(16'h0003);
    chk(count, 16'h0003, "stopped write count");
    chk(reload, 16'h0003, "stopped write reload");
    // timer mode, undivided, pulse output
    cfg(8'h04, SRC_PIN, 1'b0, 16'h0003);
    chk({14'h0, run, oe}, 16'h3, "running and pulse oe");
    irq_gap(g);
    chk(16'(g), 16'd4, "timer period");
    wrt(16'h0005);
    chk(reload, 16'h0005, "running write reload");
    irq_gap(g);
    chk(16'(g), 16'd6, "new period after reload");
    p0 = pin_q;
    irq_gap(g);
    chk({15'h0, pin_q}, {15'h0, ~p0}, "output toggles");
    start = 1'b0;
    repeat (2) @(negedge clk);
    c = count;
    repeat (5) @(negedge clk);
    chk(count, c, "stop holds");
    // prescaled sources with the subclock running
    pin_partner_i.set_pins(1'b1, 1'b0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      cfg({2'(k + 1), 6'h00}, SRC_PIN, 1'b0, 16'h0000);
      irq_gap(g);
      chk(16'(g), 16'(exp_gap[k]), "prescaled period");
    end
    pin_partner_i.set_pins(1'b1, 1'b0, 1'b0);
    // gate, active low: high pin holds, low pin counts
    cfg(8'h08, SRC_PIN, 1'b0, 16'h0100);
    repeat (10) @(negedge clk);
    chk(count, 16'h0100, "gate closed");
    pin_partner_i.set_pins(1'b0, 1'b0, 1'b0);
    repeat (10) @(negedge clk);
    c = count;
    repeat (5) @(negedge clk);
    chk(count, c - 16'h0005, "gate open");
    pin_partner_i.set_pins(1'b1, 1'b0, 1'b0);
    // event mode, other-timer flow, up with reload
    cfg(8'h01, SRC_OTHER, 1'b1, 16'hfffe);
    flow(1'b1, seen);
    chk(count, 16'hffff, "event up");
    chk({14'h0, seen}, 16'h0, "no early request");
    flow(1'b1, seen);
    chk(count, 16'hfffe, "overflow reload");
    chk({14'h0, seen}, 16'h3, "overflow request");
    // free-run wraps with request
    cfg(8'h41, SRC_OTHER, 1'b1, 16'hffff);
    flow(1'b1, seen);
    chk(count, 16'h0000, "free-run wrap");
    chk({14'h0, seen}, 16'h3, "free-run request");
    // down count from the second-group source
    cfg(8'h01, SRC_SECOND, 1'b0, 16'h0001);
    flow(1'b0, seen);
    chk(count, 16'h0000, "event down");
    flow(1'b0, seen);
    chk(count, 16'h0001, "underflow reload");
    chk({14'h0, seen}, 16'h3, "underflow request");
    flow(1'b1, seen);
    chk(count, 16'h0001, "unselected source");
    chk({14'h0, seen}, 16'h0, "unselected no request");
    // direction from the output pin overrides software
    pin_partner_i.set_pins(1'b1, 1'b1, 1'b0);
    cfg(8'h11, SRC_SECOND, 1'b0, 16'h0100);
    flow(1'b0, seen);
    chk(count, 16'h0101, "pin direction up");
    pin_partner_i.set_pins(1'b1, 1'b0, 1'b0);
    // pin edges, rising then falling
    cfg(8'h09, SRC_PIN, 1'b1, 16'h0010);
    pin_partner_i.pulses(5);
    chk(count, 16'h0015, "rising edges");
    cfg(8'h01, SRC_PIN, 1'b0, 16'h0010);
    pin_partner_i.pulses(3);
    chk(count, 16'h000d, "falling edges");
    // single-shot code is not built here: the counter holds
    cfg(8'h02, SRC_PIN, 1'b0, 16'h0007);
    repeat (6) @(negedge clk);
    chk(count, 16'h0007, "unbuilt mode holds");
    // event pulse output, then a mid-run reset with the count pin high
    cfg(8'h0d, SRC_PIN, 1'b1, 16'hffff);
    p0 = pin_q;
    pin_partner_i.pulses(1);
    chk({15'h0, pin_q}, {15'h0, ~p0}, "event output toggles");
    rstn = 1'b0;
    @(negedge clk);
    chk({run, oe, pin_q, 13'h0}, 16'h0, "mid-run reset flags");
    chk(reload, 16'h0000, "mid-run reset reload");
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    chk({run, oe, pin_q, 13'h0}, 16'hc000, "flags after reset");
    chk(count, 16'h0000, "no false edge after reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
